// ### adc_output_sync.sv
// What this block does
// R1: Sample data flows correctly whether or not the sync input is ever driven or the marker read.
// R2: A single pulse, a held step or a pulse train on the sync input each resync per rising edge.
// R3: In divide-by-2 modes the far side repeats sync pulses no faster than half the sample clock.
// R4: In divide-by-4 modes the far side repeats sync pulses no faster than a quarter of it.
// R5: A periodic sync rate should be the sample clock over an even integer to keep clock phase.
// R6: In single bus mode the bus A marker rides with the sample present at sync capture.
// R7: In dual bus modes the bus B marker rides with the sample present at sync capture.
// R8: Every captured sync makes exactly one marker that travels the pipeline as a data bit.
// R9: Single bus mode puts every sample on bus A at full rate and holds bus B inactive.
// R10: With no sync the divided clock starts at any phase while data stays valid.
// R11: Modes are single bus, dual aligned with divide by 2 or 4, and dual staggered divide by 4.
// R12: The fine sample-clock skew is a 6-bit code.
// R13: The coarse sample-clock skew is a 5-bit code.
// R14: Offset is held as a 9-bit code and gain as a 12-bit code, set by software.
// R15: Latency is 7 for single A, 7.5 and 8.5 for aligned A and B, 7.5 for staggered; the code rounds these up to 8, 9 and 8.
// R16: Dual modes send consecutive samples alternately to bus A and bus B at half rate each.
module adc_output_sync
	import adc_sync_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Converter core and sync pin
	input wire logic [SAMPLE_W-1:0] sample_in,
	input wire logic sync_reset_input,
	// Output buses
	output logic [SAMPLE_W-1:0] bus_a_data,
	output logic bus_a_frame_marker,
	output logic [SAMPLE_W-1:0] bus_b_data,
	output logic bus_b_frame_marker,
	output logic divided_output_clock,
	// Analog trims
	output logic [OFFSET_W-1:0] offset_code,
	output logic [GAIN_W-1:0] gain_code,
	output logic [FINE_W-1:0] fine_skew_code,
	output logic [COARSE_W-1:0] coarse_skew_code,
	// AXI4-Lite write
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	typedef struct packed {
		// Sync pin capture
		logic sync_meta;
		logic sync_stable;
		logic sync_prev;
		// Demux and divider
		logic phase;
		logic [1:0] div_cnt;
		logic clk_out;
		bus_word_t bus_a;
		bus_word_t bus_b;
		// Software registers
		out_mode_t mode;
		logic [OFFSET_W-1:0] offset;
		logic [GAIN_W-1:0] gain;
		logic [FINE_W-1:0] fine;
		logic [COARSE_W-1:0] coarse;
		logic [COUNT_W-1:0] event_count;
		// AXI write side
		logic aw_held;
		logic [AXI_ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [AXI_DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		// AXI read side
		logic arready;
		logic rvalid;
		logic [AXI_DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} state_t;

	state_t st;
	state_t next_st;
	lane_t in_lane;
	lane_t [PIPE_DEPTH-1:0] taps;
	logic sync_event;

	// ==========================================================
	// Byte-lane merge for register writes
	function automatic logic [AXI_DATA_W-1:0] merge(
		input logic [AXI_DATA_W-1:0] old_val,
		input logic [AXI_DATA_W-1:0] new_val,
		input logic [3:0] strb
	);
		logic [AXI_DATA_W-1:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// ==========================================================
	// Pipeline carrying sample, marker and demux phase
	sample_delay_line u_delay (
		.clk(clk),
		.rst_n(rst_n),
		.din(in_lane),
		.taps(taps)
	);

	// A step or a train both resync once per rising edge seen
	assign sync_event = st.sync_stable & ~st.sync_prev; // [R2]

	always_comb begin
		in_lane.data = sample_in;
		in_lane.marker = sync_event; // [R8]
		// Marked sample is forced to the B slot, so in dual modes it lands on bus B
		in_lane.phase = sync_event ? 1'b1 : st.phase; // [R7]
	end

	// ==========================================================
	// Next state
	always_comb begin
		logic [AXI_DATA_W-1:0] wr_word;
		logic [AXI_ADDR_W-1:0] wr_addr;
		logic [AXI_ADDR_W-1:0] rd_addr;
		wr_word = '0;
		wr_addr = '0;
		rd_addr = '0;
		next_st = st;

		// Pin passes two flops before anything looks at it
		next_st.sync_meta = sync_reset_input;
		next_st.sync_stable = st.sync_meta;
		next_st.sync_prev = st.sync_stable;

		// Demux slot alternates every sample, restarts on sync
		next_st.phase = ~in_lane.phase; // [R16]

		// Free-running divider; without sync its phase is whatever reset left [R10]
		if (sync_event) begin
			next_st.div_cnt = 2'h0; // [R2]
			next_st.event_count = st.event_count + 16'h0001;
		end else begin
			next_st.div_cnt = st.div_cnt + 2'h1;
		end
		case (st.mode)
			MODE_SINGLE,
			MODE_DUAL_ALIGN_DIV2: begin
				next_st.clk_out = next_st.div_cnt[0]; // [R11]
			end
			default: begin
				next_st.clk_out = next_st.div_cnt[1]; // [R11]
			end
		endcase

		// Output buses; data flows with or without sync, which only moves the A/B split [R1]
		case (st.mode)
			MODE_SINGLE: begin
				next_st.bus_a.data = taps[LAT_SBM_A-1].data; // [R9] [R15]
				next_st.bus_a.marker = taps[LAT_SBM_A-1].marker; // [R6]
				next_st.bus_b = '0; // [R9]
			end
			MODE_DUAL_ALIGN_DIV2,
			MODE_DUAL_ALIGN_DIV4: begin
				// B taps one deeper than A, so both reload on the same edge
				if (!taps[LAT_DBA_A-1].phase) begin
					next_st.bus_a.data = taps[LAT_DBA_A-1].data; // [R15] [R16]
					next_st.bus_a.marker = taps[LAT_DBA_A-1].marker;
				end
				if (taps[LAT_DBA_B-1].phase) begin
					next_st.bus_b.data = taps[LAT_DBA_B-1].data; // [R15] [R16]
					next_st.bus_b.marker = taps[LAT_DBA_B-1].marker; // [R7]
				end
			end
			MODE_DUAL_STAGGER_DIV4: begin
				// Same tap for both, so the buses reload on alternate edges
				if (!taps[LAT_DBS-1].phase) begin
					next_st.bus_a.data = taps[LAT_DBS-1].data; // [R15] [R16]
					next_st.bus_a.marker = taps[LAT_DBS-1].marker;
				end else begin
					next_st.bus_b.data = taps[LAT_DBS-1].data; // [R15] [R16]
					next_st.bus_b.marker = taps[LAT_DBS-1].marker; // [R7]
				end
			end
			default: begin
				next_st.bus_a = '0;
				next_st.bus_b = '0;
			end
		endcase

		// ======================================================
		// AXI write: address and data taken in either order
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_held = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.aw_held && st.w_held && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			wr_addr = {st.aw_addr[AXI_ADDR_W-1:2], 2'b00};
			case (wr_addr)
				ADDR_CTRL: begin
					wr_word = merge(AXI_DATA_W'(st.mode), st.wdata, st.wstrb);
					next_st.mode = out_mode_t'(wr_word[CTRL_MODE_LSB +: 2]); // [R11]
				end
				ADDR_OFFSET: begin
					wr_word = merge(AXI_DATA_W'(st.offset), st.wdata, st.wstrb);
					next_st.offset = wr_word[OFFSET_W-1:0]; // [R14]
				end
				ADDR_GAIN: begin
					wr_word = merge(AXI_DATA_W'(st.gain), st.wdata, st.wstrb);
					next_st.gain = wr_word[GAIN_W-1:0]; // [R14]
				end
				ADDR_SKEW: begin
					wr_word = '0;
					wr_word[SKEW_FINE_LSB +: FINE_W] = st.fine;
					wr_word[SKEW_COARSE_LSB +: COARSE_W] = st.coarse;
					wr_word = merge(wr_word, st.wdata, st.wstrb);
					next_st.fine = wr_word[SKEW_FINE_LSB +: FINE_W]; // [R12]
					next_st.coarse = wr_word[SKEW_COARSE_LSB +: COARSE_W]; // [R13]
				end
				ADDR_STATUS: begin
					// Read-only; the write is accepted and dropped
					next_st.bresp = RESP_OKAY;
				end
				default: begin
					next_st.bresp = RESP_SLVERR;
				end
			endcase
		end
		// Hold off new address and data until the response is taken
		next_st.awready = !next_st.aw_held && !next_st.bvalid;
		next_st.wready = !next_st.w_held && !next_st.bvalid;

		// ======================================================
		// AXI read: one outstanding, answered on the next edge
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st.arready) begin
			rd_addr = {s_axi_araddr[AXI_ADDR_W-1:2], 2'b00};
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			next_st.rdata = '0;
			case (rd_addr)
				ADDR_CTRL: begin
					next_st.rdata[CTRL_MODE_LSB +: 2] = st.mode;
				end
				ADDR_OFFSET: begin
					next_st.rdata[OFFSET_W-1:0] = st.offset;
				end
				ADDR_GAIN: begin
					next_st.rdata[GAIN_W-1:0] = st.gain;
				end
				ADDR_SKEW: begin
					next_st.rdata[SKEW_FINE_LSB +: FINE_W] = st.fine;
					next_st.rdata[SKEW_COARSE_LSB +: COARSE_W] = st.coarse;
				end
				ADDR_STATUS: begin
					next_st.rdata[STATUS_COUNT_LSB +: COUNT_W] = st.event_count;
					next_st.rdata[STATUS_PHASE_LSB +: 2] = st.div_cnt;
				end
				default: begin
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end
		next_st.arready = !next_st.rvalid;
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.mode <= MODE_RST;
			st.offset <= OFFSET_RST;
			st.gain <= GAIN_RST;
			st.fine <= FINE_RST;
			st.coarse <= COARSE_RST;
			st.awready <= 1'b1;
			st.wready <= 1'b1;
			st.arready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Outputs, all straight from state flops
	assign bus_a_data = st.bus_a.data;
	assign bus_a_frame_marker = st.bus_a.marker;
	assign bus_b_data = st.bus_b.data;
	assign bus_b_frame_marker = st.bus_b.marker;
	assign divided_output_clock = st.clk_out;
	assign offset_code = st.offset;
	assign gain_code = st.gain;
	assign fine_skew_code = st.fine;
	assign coarse_skew_code = st.coarse;
	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bresp = st.bresp;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_arready = st.arready;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign s_axi_rvalid = st.rvalid;

endmodule // adc_output_sync

// ### adc_sync_pkg.sv
package adc_sync_pkg;

	// ==========================================================
	// Widths
	localparam int SAMPLE_W = 12;
	localparam int OFFSET_W = 9;
	localparam int GAIN_W = 12;
	localparam int FINE_W = 6;
	localparam int COARSE_W = 5;
	localparam int COUNT_W = 16;
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;

	// ==========================================================
	// Output latency, in half sample-clock cycles as specified
	localparam int LAT_SBM_A_HALF = 14;
	localparam int LAT_DBA_A_HALF = 15;
	localparam int LAT_DBA_B_HALF = 17;
	localparam int LAT_DBS_HALF = 15;
	// One clock only, so half cycles round up to whole cycles
	localparam int LAT_SBM_A = (LAT_SBM_A_HALF + 1) / 2;
	localparam int LAT_DBA_A = (LAT_DBA_A_HALF + 1) / 2;
	localparam int LAT_DBA_B = (LAT_DBA_B_HALF + 1) / 2;
	localparam int LAT_DBS = (LAT_DBS_HALF + 1) / 2;
	// The output register adds one stage, so taps sit one shallower
	localparam int PIPE_DEPTH = LAT_DBA_B;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [AXI_ADDR_W-1:0] ADDR_CTRL = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] ADDR_OFFSET = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] ADDR_GAIN = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] ADDR_SKEW = 8'h0c;
	localparam logic [AXI_ADDR_W-1:0] ADDR_STATUS = 8'h10;

	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int SKEW_FINE_LSB = 0;
	localparam int SKEW_COARSE_LSB = 8;
	localparam int STATUS_COUNT_LSB = 0;
	localparam int STATUS_PHASE_LSB = 16;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Output arrangements
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'b00,
		MODE_DUAL_ALIGN_DIV2 = 2'b01,
		MODE_DUAL_ALIGN_DIV4 = 2'b10,
		MODE_DUAL_STAGGER_DIV4 = 2'b11
	} out_mode_t;

	// Reset values
	localparam out_mode_t MODE_RST = MODE_SINGLE;
	localparam logic [OFFSET_W-1:0] OFFSET_RST = 9'h100;
	localparam logic [GAIN_W-1:0] GAIN_RST = 12'h800;
	localparam logic [FINE_W-1:0] FINE_RST = 6'h00;
	localparam logic [COARSE_W-1:0] COARSE_RST = 5'h00;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic phase;
		logic marker;
		logic [SAMPLE_W-1:0] data;
	} lane_t;

	typedef struct packed {
		logic marker;
		logic [SAMPLE_W-1:0] data;
	} bus_word_t;

endpackage

// ### sample_delay_line.sv
module sample_delay_line
	import adc_sync_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Stream in
	input lane_t din,
	// Every stage, tap k holds the sample taken k+1 edges ago
	output lane_t [PIPE_DEPTH-1:0] taps
);

	typedef struct packed {
		lane_t [PIPE_DEPTH-1:0] stage;
	} delay_state_t;

	delay_state_t st;
	delay_state_t next_st;

	// ==========================================================
	// Shift, marker rides along as a data bit
	always_comb begin
		next_st = st;
		next_st.stage[0] = din;
		for (int i = 1; i < PIPE_DEPTH; i++) begin
			next_st.stage[i] = st.stage[i-1];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign taps = st.stage;

endmodule // sample_delay_line

// ### capture_model.sv
module capture_model
	import adc_sync_pkg::*;
(
	// Clock
	input wire logic clk,
	// Buses
	input wire logic [SAMPLE_W-1:0] bus_a_data,
	input wire logic bus_a_frame_marker,
	input wire logic [SAMPLE_W-1:0] bus_b_data,
	input wire logic bus_b_frame_marker,
	// Sync pin
	output logic sync_reset_input
);
	timeunit 1ns;
	timeprecision 1ps;
	int marks_a = 0;
	int marks_b = 0;
	logic pa = 1'b0;
	logic pb = 1'b0;
	logic [SAMPLE_W-1:0] marked_a = '0;
	logic [SAMPLE_W-1:0] marked_b = '0;
	initial sync_reset_input = 1'b0;
	// =========================================
	// Capture: marker rides as a data bit, one count per bus word
	always @(posedge clk) begin
		if (bus_a_frame_marker === 1'b1 && !pa) begin
			marks_a++;
			marked_a = bus_a_data;
		end
		if (bus_b_frame_marker === 1'b1 && !pb) begin
			marks_b++;
			marked_b = bus_b_data;
		end
		pa = bus_a_frame_marker;
		pb = bus_b_frame_marker;
	end
	// Callers keep the low gap at least 2 edges; back-to-back calls repeat every len plus 21 edges
	task automatic pulse(input int len);
		sync_reset_input <= 1'b1;
		repeat (len) @(posedge clk);
		sync_reset_input <= 1'b0;
	endtask
endmodule // capture_model

// ### adc_output_sync_asserts.sv
module adc_output_sync_asserts
	import adc_sync_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Sync and outputs
	input wire logic sync_reset_input,
	input logic bus_a_frame_marker,
	input logic bus_b_frame_marker,
	input logic [OFFSET_W-1:0] offset_code,
	input logic [GAIN_W-1:0] gain_code,
	// Register bus
	input wire logic s_axi_awvalid,
	input logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [AXI_DATA_W-1:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Sync rises seen, so a marker can be traced to its cause
	logic sync_d;
	logic [12:0] hist;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_d <= 1'b0;
			hist <= '0;
		end else begin
			sync_d <= sync_reset_input;
			hist <= {hist[11:0], sync_reset_input & ~sync_d};
		end
	end
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_wait;
		!s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	endsequence
	AST_WR_ANSWER: assert property (wr_taken |=> wr_wait ##1 s_axi_bvalid)
		else $error("write answer late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("bresp dropped");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write not closed");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("rdata dropped");
	AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
		else $error("error read not zero");
	AST_TRIM_WRITE: assert property ($changed(offset_code) || $changed(gain_code) |-> $rose(s_axi_bvalid))
		else $error("trim changed without write");
	AST_ONE_MARK: assert property (!(bus_a_frame_marker && bus_b_frame_marker))
		else $error("markers on both buses");
	AST_MARK_CAUSE: assert property ($rose(bus_a_frame_marker) || $rose(bus_b_frame_marker) |-> |hist[12:8])
		else $error("marker without sync");
endmodule // adc_output_sync_asserts

bind adc_output_sync adc_output_sync_asserts adc_output_sync_asserts_i (.clk, .rst_n,
	.sync_reset_input, .bus_a_frame_marker, .bus_b_frame_marker, .offset_code, .gain_code,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready);

// ### test_adc_output_sync.sv
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_adc_output_sync
	import adc_sync_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {out_mode_t m; int tog; int la; int lb;} row_t;
	row_t rows[4] = '{'{MODE_SINGLE, 16, LAT_SBM_A, 0}, '{MODE_DUAL_ALIGN_DIV2, 16, LAT_DBA_A, LAT_DBA_B},
		'{MODE_DUAL_ALIGN_DIV4, 8, LAT_DBA_A, LAT_DBA_B}, '{MODE_DUAL_STAGGER_DIV4, 8, LAT_DBS, LAT_DBS}};
	logic [7:0] ra[3] = '{ADDR_OFFSET, ADDR_GAIN, ADDR_SKEW};
	logic [31:0] rx[3] = '{32'h1ff, 32'hfff, 32'h1f3f};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [SAMPLE_W-1:0] sample_in = '0;
	logic sync_reset_input, bus_a_frame_marker, bus_b_frame_marker, divided_output_clock, pd;
	logic [SAMPLE_W-1:0] bus_a_data, bus_b_data, pa, pb, expv;
	logic [OFFSET_W-1:0] offset_code;
	logic [GAIN_W-1:0] gain_code;
	logic [FINE_W-1:0] fine_skew_code;
	logic [COARSE_W-1:0] coarse_skew_code;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	int fails = 0, total_checks = 0, sent = 0, ntog, mk;
	adc_output_sync adc_output_sync_i (.clk, .rst_n, .sample_in, .sync_reset_input, .bus_a_data,
		.bus_a_frame_marker, .bus_b_data, .bus_b_frame_marker, .divided_output_clock, .offset_code,
		.gain_code, .fine_skew_code, .coarse_skew_code, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	capture_model capture_model_i (.clk, .bus_a_data, .bus_a_frame_marker, .bus_b_data,
		.bus_b_frame_marker, .sync_reset_input);
	always #2.5 clk = ~clk;
	// A ramp makes every sample unique, so latency shows as a fixed difference
	always @(posedge clk) sample_in <= sample_in + 12'h001;
	// =========================================
	// Register bus
	// A lag holds ready back, so the slave must keep its answer standing meanwhile
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input int lag = 0);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (lag == 0);
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (lag == 1) s_axi_bready <= 1'b1;
			lag--;
		end while (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input int lag = 0);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (lag == 0);
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (lag == 1) s_axi_rready <= 1'b1;
			lag--;
		end while (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1);
		rd_v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// One sync pulse; the marked sample is the one taken three edges later
	task automatic sync_one(input int len, input bit on_b);
		@(posedge clk);
		expv = sample_in + 12'h003;
		mk = capture_model_i.marks_a + capture_model_i.marks_b;
		capture_model_i.pulse(len);
		sent++;
		repeat (20) @(posedge clk);
		`CHK(capture_model_i.marks_a + capture_model_i.marks_b - mk, 1)
		if (on_b) `CHK(capture_model_i.marked_b, expv)
		else `CHK(capture_model_i.marked_a, expv)
	endtask
	task automatic summarize();
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge clk);
		fails++;
		summarize();
	end
	// =========================================
	// Sequence
	initial begin
		repeat (5) @(posedge clk);
		`CHK({offset_code, gain_code}, {OFFSET_RST, GAIN_RST})
		`CHK(divided_output_clock, 1'b0)
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			wr(ADDR_CTRL, {30'h0, rows[i].m}, 4'hf);
			rd(ADDR_CTRL);
			`CHK(rd_v[1:0], rows[i].m)
			repeat (12) @(posedge clk);
			#1;
			pa = bus_a_data;
			pb = bus_b_data;
			pd = divided_output_clock;
			ntog = 0;
			for (int k = 0; k < 16; k++) begin
				@(posedge clk);
				#1;
				if (divided_output_clock !== pd) ntog++;
				pd = divided_output_clock;
				if (bus_a_data !== pa) `CHK(bus_a_data, sample_in - 12'(rows[i].la) - 12'h1)
				if (rows[i].lb == 0) `CHK({bus_b_frame_marker, bus_b_data}, 13'h0)
				else begin
					if (bus_b_data !== pb) `CHK(bus_b_data, sample_in - 12'(rows[i].lb) - 12'h1)
					if (bus_a_data !== pa && k > 0) `CHK(bus_a_data, pa + 12'h2)
					`CHK(bus_a_data[0] ^ bus_b_data[0], 1'b1)
				end
				pa = bus_a_data;
				pb = bus_b_data;
			end
			`CHK(ntog, rows[i].tog)
			sync_one(2, rows[i].lb != 0);
		end
		sync_one(20, 1'b1);
		for (int j = 0; j < 3; j++) sync_one(2, 1'b1);
		rd(ADDR_STATUS);
		`CHK(rd_v[15:0], 16'(sent))
		// Last event cleared the divider 20 edges before this read, a multiple of 4
		`CHK(rd_v[17:16], 2'h0)
		wr(ADDR_STATUS, 32'h0, 4'hf);
		rd(ADDR_STATUS);
		`CHK(rd_v[15:0], 16'(sent))
		foreach (ra[j]) begin
			wr(ra[j], 32'hffff_ffff, 4'hf, 3 * j);
			rd(ra[j], 3 * j);
			`CHK(rd_v, rx[j])
		end
		`CHK({coarse_skew_code, fine_skew_code, offset_code}, 20'hfffff)
		wr(ADDR_GAIN, 32'h0, 4'h1);
		`CHK(gain_code, 12'hf00)
		wr(8'h14, 32'h1, 4'hf);
		`CHK(rs, RESP_SLVERR)
		rd(8'h14);
		`CHK({rs, rd_v}, {RESP_SLVERR, 32'h0})
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK({offset_code, gain_code, bus_a_data}, {OFFSET_RST, GAIN_RST, 12'h0})
		rst_n <= 1'b1;
		rd(ADDR_CTRL);
		`CHK(rd_v, 32'h0)
		summarize();
	end
endmodule // test_adc_output_sync
